// *** design/supply_monitor_power_modes.sv ***
// supply supervision, reset generation and idle / power-down sequencing
//
// What this block does
// R1: hold core reset at power-up until supply passes rise threshold.
// R2: assert internal reset when supply falls below fall threshold.
// R3: ignore supply dips shorter than the glitch duration.
// R4: idle request bit set by write enters idle after that write.
// R5: idle gates core clock, keeps interrupt, timer 0, serial clocked.
// R6: idle holds registers and pins; address and program strobes high.
// R7: enabled interrupt clears idle request bit and ends idle.
// R8: hardware reset ends idle; 24 oscillator periods suffice.
// R9: power-down stops oscillator after invoking write; state kept.
// R10: power-down exit only by reset or enabled external interrupt.
// R11: outside party wakes only after supply restored, holds long enough.
// R12: low wake pin restarts oscillator; exit completes on its release.
// R13: with both wakes enabled, first release completes exit.
// R14: interrupt exit leaves RAM and registers unchanged.
// R15: ports keep their pre-power-down output state.
// R16: second interrupt combines its pin, card presence and receive.
// R17: receive low over 100 us wakes when receive and irq b enabled.
// R18: card wake needs presence, irq b and global enables set.
// R19: handler inverts presence level select, clears presence flag.
// R20: power-down bit cleared on interrupt or reset; beats idle.
// R21: comparators and wake pins pass two flip-flops first.
// R22: filter counter needs configurable consecutive low samples.
module supply_monitor_power_modes #(
  parameter int FCW         = 8,
  parameter int RX_WAKE_CNT = pwr_pkg::RX_WAKE_CYC,
  parameter int OSC_CNT     = pwr_pkg::OSC_START_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ext_rst_i,
  input  wire logic       above_rise_i,
  input  wire logic       below_fall_i,
  input  wire logic       external_irq_a_i,
  input  wire logic       external_irq_b_i,
  input  wire logic       card_presence_input_i,
  input  wire logic       rxd_i,
  input  wire logic       periph_irq_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            core_rst_o,
  output logic            core_clk_en_o,
  output logic            periph_clk_en_o,
  output logic            osc_en_o,
  output logic            strobes_high_o,
  output logic            hold_ports_o,
  output logic            wake_irq_a_o,
  output logic            wake_irq_b_o
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [5:0] raw_in;
  logic [5:0] syn;
  logic       rise_ok;
  logic       fall_low;
  logic       irq_a_s;
  logic       irq_b_s;
  logic       card_presence_input_s;
  logic       rxd_s;

  assign raw_in = {above_rise_i, below_fall_i, external_irq_a_i,
                   external_irq_b_i, card_presence_input_i, rxd_i};

  sync2 #(
    .W     (6),
    .RST_V (32'h0000_000F)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (raw_in), // R21
    .q_o     (syn)
  );

  assign {rise_ok, fall_low, irq_a_s, irq_b_s, card_presence_input_s, rxd_s} = syn;

  ////////////////////////////////////////////////////////////////////////////
  // glitch filter on low supply

  logic [FCW-1:0] filt_lim_r;
  logic [3:0]     div_r;
  logic           tick;
  logic           supply_fail;

  assign tick = (div_r == 4'(pwr_pkg::FILTER_DIV - 1));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 4'h0;
    end else begin
      div_r <= tick ? 4'h0 : div_r + 4'h1;
    end
  end

  glitch_filter #(
    .CW (FCW)
  ) u_filt (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (tick),
    .low_i   (fall_low),
    .limit_i (filt_lim_r),
    .fail_o  (supply_fail)
  );

  ////////////////////////////////////////////////////////////////////////////
  // supervisor reset

  logic sup_rst_r;
  logic [4:0] ext_cnt_r;
  logic hw_rst;

  // reset leaves only once the rise comparator reports a good supply
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sup_rst_r <= 1'b1;
    end else if (supply_fail) begin
      sup_rst_r <= 1'b1; // R2
    end else if (sup_rst_r && rise_ok) begin
      sup_rst_r <= 1'b0; // R1
    end
  end

  // external reset is taken once held for two machine cycles
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_cnt_r <= 5'h00;
    end else if (!ext_rst_i) begin
      ext_cnt_r <= 5'h00;
    end else if (ext_cnt_r != 5'(pwr_pkg::RESET_OSC_CYC)) begin
      ext_cnt_r <= ext_cnt_r + 5'h01;
    end
  end

  assign hw_rst = sup_rst_r || (ext_cnt_r == 5'(pwr_pkg::RESET_OSC_CYC)); // R8

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] mode_r;
  logic [7:0] wake_r;
  logic       ex0;
  logic       ex1;
  logic       ea;
  logic       lvl;
  logic       wake_a;
  logic       wake_b;
  logic       rx_wake;
  logic       pres_evt;
  logic       any_irq;
  logic       card_presence_input_d_r;
  logic [13:0] rx_cnt_r;

  assign ex0 = wake_r[pwr_pkg::WAKE_EX0_BIT];
  assign ex1 = wake_r[pwr_pkg::WAKE_EX1_BIT];
  assign ea  = wake_r[pwr_pkg::WAKE_EA_BIT];
  assign lvl = wake_r[pwr_pkg::WAKE_LEVEL_BIT];

  // receive held low past the wake time counts as a wake on irq b
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt_r <= 14'h0000;
    end else if (rxd_s || !wake_r[pwr_pkg::WAKE_RECEIVE_WAKE_ENABLE_BIT]) begin
      rx_cnt_r <= 14'h0000;
    end else if (rx_cnt_r != 14'(RX_WAKE_CNT)) begin
      rx_cnt_r <= rx_cnt_r + 14'h0001;
    end
  end

  assign rx_wake = ex1 && (rx_cnt_r == 14'(RX_WAKE_CNT)); // R17

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      card_presence_input_d_r <= 1'b1;
    end else begin
      card_presence_input_d_r <= card_presence_input_s;
    end
  end

  // presence edge toward the selected level; software flips the select
  assign pres_evt = (card_presence_input_s == wake_r[pwr_pkg::WAKE_PRESENCE_LEVEL_SELECT_BIT]) &&
                    (card_presence_input_d_r != card_presence_input_s);

  assign wake_a = ex0 && !irq_a_s; // R10
  assign wake_b = ex1 && (!irq_b_s || rx_wake ||
                  (wake_r[pwr_pkg::WAKE_PFLAG_BIT] &&
                   wake_r[pwr_pkg::WAKE_PRESENCE_IRQ_ENABLE_BIT] && ea)); // R16 R18
  assign any_irq = (ea && periph_irq_i) || wake_a || wake_b;

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  pwr_pkg::pwr_state_t st_r;
  pwr_pkg::pwr_state_t st_nxt;
  logic [7:0] osc_cnt_r;
  logic       wake_low;

  assign wake_low = wake_a || wake_b;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      pwr_pkg::ST_POR: begin
        if (!hw_rst) st_nxt = pwr_pkg::ST_RUN;
      end
      pwr_pkg::ST_RUN: begin
        if (wr_i && addr_i == pwr_pkg::ADDR_MODE) begin
          if (wdata_i[pwr_pkg::MODE_PD_BIT]) begin
            st_nxt = pwr_pkg::ST_PD; // R9 R20
          end else if (wdata_i[pwr_pkg::MODE_IDLE_BIT]) begin
            st_nxt = pwr_pkg::ST_IDLE; // R4
          end
        end
      end
      pwr_pkg::ST_IDLE: begin
        if (any_irq) st_nxt = pwr_pkg::ST_RUN; // R7
      end
      pwr_pkg::ST_PD: begin
        if (wake_low) st_nxt = pwr_pkg::ST_OSC_WAIT; // R12
      end
      pwr_pkg::ST_OSC_WAIT: begin
        if (osc_cnt_r == 8'(OSC_CNT)) st_nxt = pwr_pkg::ST_PD_EXIT;
      end
      pwr_pkg::ST_PD_EXIT: begin
        // first released pin completes the exit
        if ((wake_irq_a_o && !wake_a) || (wake_irq_b_o && !wake_b) ||
            !wake_low) begin
          st_nxt = pwr_pkg::ST_RUN; // R12 R13
        end
      end
      default: st_nxt = pwr_pkg::ST_POR;
    endcase
    if (hw_rst) st_nxt = pwr_pkg::ST_POR; // R8 R10
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= pwr_pkg::ST_POR;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_cnt_r <= 8'h00;
    end else if (st_r != pwr_pkg::ST_OSC_WAIT) begin
      osc_cnt_r <= 8'h00;
    end else begin
      osc_cnt_r <= osc_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes; hardware clears win over software sets

  logic mode_clr;

  assign mode_clr = hw_rst || (st_r == pwr_pkg::ST_IDLE && any_irq) ||
                    (st_r == pwr_pkg::ST_PD_EXIT && st_nxt == pwr_pkg::ST_RUN);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= pwr_pkg::MODE_RESET;
    end else if (hw_rst) begin
      mode_r <= pwr_pkg::MODE_RESET; // R20
    end else begin
      if (wr_i && addr_i == pwr_pkg::ADDR_MODE) begin
        mode_r <= wdata_i & 8'h07;
      end
      if (mode_clr) begin
        mode_r[pwr_pkg::MODE_IDLE_BIT] <= 1'b0; // R7
        mode_r[pwr_pkg::MODE_PD_BIT]   <= 1'b0; // R20
      end
    end
  end

  // presence flag: hardware set beats software clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_r <= pwr_pkg::WAKE_RESET;
    end else if (hw_rst) begin
      wake_r <= pwr_pkg::WAKE_RESET;
    end else begin
      if (wr_i && addr_i == pwr_pkg::ADDR_WAKE) begin
        wake_r <= wdata_i; // R19
      end
      if (pres_evt) begin
        wake_r[pwr_pkg::WAKE_PFLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_lim_r <= FCW'(pwr_pkg::FILTER_RESET);
    end else if (wr_i && addr_i == pwr_pkg::ADDR_FILTER) begin
      filt_lim_r <= FCW'(wdata_i); // R22
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        pwr_pkg::ADDR_MODE:   rdata_o <= mode_r;
        pwr_pkg::ADDR_WAKE:   rdata_o <= wake_r;
        pwr_pkg::ADDR_STATUS: rdata_o <= {3'h0, sup_rst_r, supply_fail,
                                          3'(st_r)};
        pwr_pkg::ADDR_FILTER: rdata_o <= 8'(filt_lim_r);
        default:              rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered

  pwr_pkg::clk_ctl_t ctl;

  always_comb begin
    ctl = '{core_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
            hold_strobes: 1'b0};
    case (st_nxt)
      pwr_pkg::ST_IDLE: begin
        ctl.core_clk_en  = 1'b0; // R5
        ctl.hold_strobes = 1'b1; // R6
      end
      pwr_pkg::ST_PD: begin
        ctl = '{core_clk_en: 1'b0, periph_clk_en: 1'b0, osc_en: 1'b0,
                hold_strobes: 1'b1}; // R9
      end
      pwr_pkg::ST_OSC_WAIT, pwr_pkg::ST_PD_EXIT: begin
        ctl.core_clk_en  = 1'b0;
        ctl.periph_clk_en = 1'b0;
        ctl.hold_strobes = 1'b1;
      end
      default: ctl.core_clk_en = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_rst_o      <= 1'b1;
      core_clk_en_o   <= 1'b0;
      periph_clk_en_o <= 1'b0;
      osc_en_o        <= 1'b1;
      strobes_high_o  <= 1'b0;
      hold_ports_o    <= 1'b0;
    end else begin
      core_rst_o      <= hw_rst;
      core_clk_en_o   <= ctl.core_clk_en;
      periph_clk_en_o <= ctl.periph_clk_en;
      osc_en_o        <= ctl.osc_en;
      strobes_high_o  <= ctl.hold_strobes;
      // R14 R15: no state is touched; ports and core simply freeze
      hold_ports_o    <= ctl.hold_strobes;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_irq_a_o <= 1'b0;
      wake_irq_b_o <= 1'b0;
    end else begin
      wake_irq_a_o <= wake_a;
      wake_irq_b_o <= wake_b;
    end
  end

endmodule : supply_monitor_power_modes

// *** design/pwr_pkg.sv ***
// shared constants and carriers for the supply monitor and power modes block
package pwr_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ADDR_MODE   = 4'h0;
  localparam logic [3:0] ADDR_WAKE   = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_FILTER = 4'h3;

  // mode control register fields
  localparam int MODE_IDLE_BIT = 0;
  localparam int MODE_PD_BIT   = 1;
  localparam int MODE_GF0_BIT  = 2;

  // wake configuration register fields
  localparam int WAKE_RECEIVE_WAKE_ENABLE_BIT  = 0;
  localparam int WAKE_PRESENCE_IRQ_ENABLE_BIT = 1;
  localparam int WAKE_EX0_BIT   = 2;
  localparam int WAKE_EX1_BIT   = 3;
  localparam int WAKE_EA_BIT    = 4;
  localparam int WAKE_LEVEL_BIT = 5;
  localparam int WAKE_PFLAG_BIT = 6;
  localparam int WAKE_PRESENCE_LEVEL_SELECT_BIT = 7;

  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] WAKE_RESET   = 8'h00;
  localparam logic [7:0] FILTER_RESET = 8'h08;

  // timing
  localparam int CLK_MHZ         = 125;
  localparam int OSC_PER_MC      = 12;
  localparam int RESET_MC        = 2;
  localparam int RESET_OSC_CYC   = RESET_MC * OSC_PER_MC;
  localparam int RX_WAKE_US      = 100;
  localparam int RX_WAKE_CYC     = RX_WAKE_US * CLK_MHZ + 1;
  localparam int OSC_START_CYC   = 64;
  localparam int FILTER_DIV      = 16;

  typedef enum logic [2:0] {
    ST_POR      = 3'b000,
    ST_RUN      = 3'b001,
    ST_IDLE     = 3'b010,
    ST_PD       = 3'b011,
    ST_OSC_WAIT = 3'b100,
    ST_PD_EXIT  = 3'b101
  } pwr_state_t;

  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic hold_strobes;
  } clk_ctl_t;

endpackage : pwr_pkg

// *** design/sync2.sv ***
// two flip-flop synchroniser for a bus of asynchronous levels
module sync2 #(
  parameter int          W     = 1,
  parameter logic [31:0] RST_V = 32'h0000_0000
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_V[W-1:0];
      q_o    <= RST_V[W-1:0];
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : sync2

// *** design/glitch_filter.sv ***
// persistence counter that qualifies the low-supply indication
module glitch_filter #(
  parameter int CW = 8
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          tick_i,
  input  wire logic          low_i,
  input  wire logic [CW-1:0] limit_i,
  output logic               fail_o
);

  logic [CW-1:0] cnt_r;

  // a dip must be seen on limit_i + 1 consecutive ticks before it counts
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      fail_o <= 1'b0;
    end else if (!low_i) begin
      cnt_r  <= '0;
      fail_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt_r >= limit_i) begin
        fail_o <= 1'b1; // R22 R3
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule : glitch_filter

// *** verification/supply_monitor_power_modes_assertions.sv ***
// port-level checks for the supply monitor and power modes block
module supply_monitor_power_modes_checker #(
  parameter int FCW         = 8,
  parameter int RX_WAKE_CNT = 20,
  parameter int OSC_CNT     = 4
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ext_rst_i,
  input  wire logic       above_rise_i,
  input  wire logic       below_fall_i,
  input  wire logic       external_irq_a_i,
  input  wire logic       external_irq_b_i,
  input  wire logic       rxd_i,
  input  wire logic       periph_irq_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic       core_rst_o,
  input  wire logic       core_clk_en_o,
  input  wire logic       periph_clk_en_o,
  input  wire logic       osc_en_o,
  input  wire logic       strobes_high_o,
  input  wire logic       hold_ports_o,
  input  wire logic       wake_irq_a_o,
  input  wire logic       wake_irq_b_o
);
  int         ext_cnt;
  int         low_cnt;
  logic [7:0] lim_r;
  logic       quiet;
  logic       mode_wr;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // no wake source may be pending, else a mode write is cut short legally
  assign quiet = !core_rst_o && !ext_rst_i && !periph_irq_i && rxd_i &&
                 external_irq_a_i && external_irq_b_i &&
                 !wake_irq_a_o && !wake_irq_b_o;
  assign mode_wr = wr_i && addr_i == pwr_pkg::ADDR_MODE;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) ext_cnt <= 0;
    else ext_cnt <= ext_rst_i ? ((ext_cnt < 40) ? ext_cnt + 1 : ext_cnt) : 0;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt <= 0;
    else low_cnt <= below_fall_i ? ((low_cnt < 9000) ? low_cnt + 1 : 9000)
                                 : 0;
  end
  // tracks the filter limit so the bound follows software changes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) lim_r <= pwr_pkg::FILTER_RESET;
    else if (wr_i && addr_i == pwr_pkg::ADDR_FILTER) lim_r <= wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////
  property p_rst_hold;
    !above_rise_i [*4] |-> core_rst_o;
  endproperty
  property p_pd_enter;
    mode_wr && wdata_i[pwr_pkg::MODE_PD_BIT] && quiet ##1 quiet
      |-> ##1 !osc_en_o;
  endproperty
  property p_idle_enter;
    mode_wr && wdata_i[1:0] == 2'b01 && quiet ##1 quiet
      |-> ##1 !core_clk_en_o && periph_clk_en_o && strobes_high_o;
  endproperty
  property p_pd_hold;
    !osc_en_o |-> hold_ports_o && !periph_clk_en_o && !core_clk_en_o;
  endproperty
  property p_wake_osc;
    !osc_en_o && (wake_irq_a_o || wake_irq_b_o) |-> ##[1:3] osc_en_o;
  endproperty
  property p_exit_wait;
    $past(osc_en_o) && !$past(periph_clk_en_o) && !core_rst_o &&
      (wake_irq_a_o || wake_irq_b_o) &&
      $stable(wake_irq_a_o) && $stable(wake_irq_b_o) |-> !core_clk_en_o;
  endproperty
  property p_ext_rst;
    ext_cnt == 32 |-> core_rst_o;
  endproperty
  property p_supply_fail;
    low_cnt == pwr_pkg::FILTER_DIV * (int'(lim_r) + 2) + 6 |-> core_rst_o;
  endproperty
  property p_unmapped;
    rd_i && addr_i > 4'h3 |=> rdata_o == 8'h00;
  endproperty

  a_rst_hold: assert property (p_rst_hold)
    else $error("core left reset with supply below rise threshold");
  a_pd_enter: assert property (p_pd_enter)
    else $error("oscillator still running after power-down write");
  a_idle_enter: assert property (p_idle_enter)
    else $error("idle clocks or strobes wrong after idle write");
  a_pd_hold: assert property (p_pd_hold)
    else $error("ports or clocks not frozen with oscillator stopped");
  a_wake_osc: assert property (p_wake_osc)
    else $error("oscillator not restarted by active wake pin");
  a_exit_wait: assert property (p_exit_wait)
    else $error("power-down exit completed while wake pin held low");
  a_ext_rst: assert property (p_ext_rst)
    else $error("long hardware reset request did not reset the core");
  a_supply_fail: assert property (p_supply_fail)
    else $error("persistent low supply did not reset the core");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned nonzero data");

  c_idle: cover property (mode_wr && wdata_i == 8'h05);
  c_pd: cover property ($fell(osc_en_o));
  c_wake: cover property ($rose(osc_en_o) && !core_rst_o);
  c_fail: cover property (low_cnt > 200);
endmodule : supply_monitor_power_modes_checker

bind supply_monitor_power_modes supply_monitor_power_modes_checker #(
  .FCW(FCW), .RX_WAKE_CNT(RX_WAKE_CNT), .OSC_CNT(OSC_CNT)
) u_checker (
  .mclk_i, .rst_n_i, .ext_rst_i, .above_rise_i, .below_fall_i,
  .external_irq_a_i, .external_irq_b_i, .rxd_i, .periph_irq_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .core_rst_o,
  .core_clk_en_o, .periph_clk_en_o, .osc_en_o, .strobes_high_o,
  .hold_ports_o, .wake_irq_a_o, .wake_irq_b_o
);

// *** verification/supply_monitor_power_modes_tb.sv ***
// self-checking bench for the supply monitor and power modes block
module supply_monitor_power_modes_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk_i, rst_n_i, ext_rst_i, above_rise_i, below_fall_i;
  logic       external_irq_a_i, external_irq_b_i, rxd_i, periph_irq_i;
  logic       card_presence_input_i, wr_i, rd_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, mon;
  logic       core_rst_o, core_clk_en_o, periph_clk_en_o, osc_en_o;
  logic       strobes_high_o, hold_ports_o, wake_irq_a_o, wake_irq_b_o;
  int         errors, n_tests;

  // short counts keep the run brief
  supply_monitor_power_modes #(.RX_WAKE_CNT(20), .OSC_CNT(4)) DUT (
    .mclk_i, .rst_n_i, .ext_rst_i, .above_rise_i, .below_fall_i,
    .external_irq_a_i, .external_irq_b_i, .card_presence_input_i,
    .rxd_i, .periph_irq_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .core_rst_o, .core_clk_en_o, .periph_clk_en_o, .osc_en_o,
    .strobes_high_o, .hold_ports_o, .wake_irq_a_o, .wake_irq_b_o
  );

  assign mon = {core_rst_o, core_clk_en_o, periph_clk_en_o, osc_en_o,
                strobes_high_o, hold_ports_o, wake_irq_a_o, wake_irq_b_o};

  always #4 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [7:0] exp, got, msk);
    n_tests++;
    if ((got & msk) !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got & msk);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  // bounded wait for bit b of the output monitor to reach v
  task automatic await(input int b, input logic v);
    for (int i = 0; i < 600; i++) begin
      if (mon[b] === v) return;
      cyc(1);
    end
    errors++;
    $display("unexpected timeout on output bit %0d: expected %b", b, v);
    complete_run();
  endtask : await

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, msk);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    chk("rdata", exp, rdata_o, msk);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(pwr_pkg::ADDR_MODE, pwr_pkg::MODE_RESET, 8'hFF);
    rd(pwr_pkg::ADDR_WAKE, pwr_pkg::WAKE_RESET, 8'hBF);
    rd(pwr_pkg::ADDR_FILTER, pwr_pkg::FILTER_RESET, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    wr(pwr_pkg::ADDR_WAKE, 8'h1C);
    rd(pwr_pkg::ADDR_WAKE, 8'h1C, 8'hBF);
  endtask : t_regs

  task automatic t_idle;
    wr(pwr_pkg::ADDR_MODE, 8'h05);
    cyc(2);
    chk("idle outputs", 8'h28, mon, 8'h68);
    rd(pwr_pkg::ADDR_MODE, 8'h05, 8'hFF);
    @(posedge mclk_i);
    periph_irq_i <= 1'b1;
    await(6, 1'b1);
    @(posedge mclk_i);
    periph_irq_i <= 1'b0;
    rd(pwr_pkg::ADDR_MODE, 8'h04, 8'hFF);
  endtask : t_idle

  task automatic t_pd;
    wr(pwr_pkg::ADDR_MODE, 8'h07);
    cyc(2);
    chk("pd outputs", 8'h04, mon, 8'hF4);
    @(posedge mclk_i);
    periph_irq_i <= 1'b1;
    cyc(10);
    chk("pd vs internal irq", 8'h00, mon, 8'h10);
    periph_irq_i     <= 1'b0;
    external_irq_a_i <= 1'b0;
    external_irq_b_i <= 1'b0;
    await(4, 1'b1);
    cyc(20);
    chk("core clock while held", 8'h00, mon, 8'h40);
    @(posedge mclk_i);
    external_irq_a_i <= 1'b1;
    await(6, 1'b1);
    @(posedge mclk_i);
    external_irq_b_i <= 1'b1;
    rd(pwr_pkg::ADDR_MODE, 8'h04, 8'hFF);
    rd(pwr_pkg::ADDR_WAKE, 8'h1C, 8'hBF);
  endtask : t_pd

  task automatic t_rx;
    wr(pwr_pkg::ADDR_WAKE, 8'h09);
    wr(pwr_pkg::ADDR_MODE, 8'h06);
    @(posedge mclk_i);
    rxd_i <= 1'b0;
    cyc(10);
    chk("short receive low", 8'h00, mon, 8'h10);
    await(4, 1'b1);
    @(posedge mclk_i);
    rxd_i <= 1'b1;
    await(6, 1'b1);
    rd(pwr_pkg::ADDR_MODE, 8'h04, 8'hFF);
  endtask : t_rx

  task automatic t_card;
    wr(pwr_pkg::ADDR_WAKE, 8'h9A);
    wr(pwr_pkg::ADDR_MODE, 8'h02);
    cyc(4);
    chk("pd before card", 8'h00, mon, 8'h10);
    card_presence_input_i <= 1'b1;
    await(4, 1'b1);
    chk("card wake b", 8'h01, mon, 8'h03);
    wr(pwr_pkg::ADDR_WAKE, 8'h1A);
    await(6, 1'b1);
    rd(pwr_pkg::ADDR_WAKE, 8'h1A, 8'hFF);
    rd(pwr_pkg::ADDR_MODE, 8'h00, 8'hFF);
  endtask : t_card

  task automatic t_ext_rst;
    @(posedge mclk_i);
    ext_rst_i <= 1'b1;
    cyc(10);
    ext_rst_i <= 1'b0;
    cyc(4);
    chk("short reset", 8'h00, mon, 8'h80);
    wr(pwr_pkg::ADDR_MODE, 8'h01);
    @(posedge mclk_i);
    ext_rst_i <= 1'b1;
    cyc(32);
    chk("reset in idle", 8'h80, mon, 8'h80);
    ext_rst_i <= 1'b0;
    await(7, 1'b0);
    rd(pwr_pkg::ADDR_MODE, 8'h00, 8'hFF);
  endtask : t_ext_rst

  task automatic t_supply;
    @(posedge mclk_i);
    below_fall_i <= 1'b1;
    cyc(48);
    below_fall_i <= 1'b0;
    cyc(40);
    chk("short dip", 8'h00, mon, 8'h80);
    below_fall_i <= 1'b1;
    await(7, 1'b1);
    @(posedge mclk_i);
    below_fall_i <= 1'b0;
    await(7, 1'b0);
  endtask : t_supply

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {mclk_i, rst_n_i, ext_rst_i, above_rise_i, below_fall_i} = 5'h00;
    {external_irq_a_i, external_irq_b_i, rxd_i} = 3'h7;
    {periph_irq_i, card_presence_input_i, wr_i, rd_i} = 4'h0;
    addr_i  = 4'h0;
    wdata_i = 8'h00;
    errors  = 0;
    n_tests = 0;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    cyc(10);
    chk("reset before supply", 8'h80, mon, 8'h80);
    above_rise_i <= 1'b1;
    await(7, 1'b0);
    t_regs();
    t_idle();
    t_pd();
    t_rx();
    t_card();
    t_ext_rst();
    t_supply();
    complete_run();
  end
endmodule : supply_monitor_power_modes_tb
